// *** rtl/fspc_top.sv ***
// flash sector program/erase sequencer with guard, protection and link port
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - erase whole array or one sector; program one byte per operation
// - erasing one sector never touches any other sector
// - tool and in-circuit modes may program or erase all sectors and options
// - in-application mode may not program or erase the boot sector
// - sector count follows array size: 4K one, 8K two, larger three
// - first two sectors 4 Kbytes at top; boot sector is F000h-FFFFh
// - read-out protection blocks flash writes, and blocks external extraction only while the link owns the pins
// - removing protection first erases the whole array automatically
// - protection is held in a dedicated option bit
// - a key sequence guards program and erase controls
// - control/status register resets to 00h and is read/write
// - one serial clock and one two-way serial data line
// - link pins belong to the link whenever the program select voltage is applied
// - RAM code chooses byte count, targets and download interface
// - in-application mode runs under software, entered by software
// - in-circuit test mode runs downloaded patterns from RAM
module fspc_top
    import fspc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [5:0]  avm_address,
    input  wire logic        avm_read,
    input  wire logic        avm_write,
    input  wire logic [3:0]  avm_byteenable,
    input  wire logic [31:0] avm_writedata,
    output logic [31:0]      avm_readdata,
    output logic             avm_waitrequest,
    input  wire logic        link_serial_clock,
    input  wire logic        link_serial_data_in,
    output logic             link_serial_data_out,
    output logic             link_serial_data_oe,
    input  wire logic        prog_select_voltage,
    input  wire logic        tool_socket_strap,
    input  wire logic        flash_done,
    output logic [15:0]      flash_addr,
    output logic [7:0]       flash_wdata,
    output logic             flash_prog,
    output logic             flash_sector_erase,
    output logic             flash_mass_erase,
    output logic [1:0]       flash_sector,
    output logic             link_pins_owned,
    output logic             ext_read_block,
    output logic             ram_exec_mode
);

    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
        logic [7:0]  ctrl;
        logic        key1_seen;
        logic        unlocked;
        logic        protect;
        logic        unprot_pend;
        fspc_mode_e  swmode;
        fspc_mode_e  mode;
        logic [15:0] addr;
        logic [7:0]  wdata;
        fspc_seq_e   seq;
        fspc_op_s    op;
        fspc_op_s    pulse;
        logic [7:0]  rx_sh;
        logic [2:0]  rx_cnt;
        logic [7:0]  rx_byte;
        logic        rx_full;
        logic [7:0]  tx_sh;
        logic [3:0]  tx_cnt;
        logic        tx_oe;
        logic        owned;
        logic        ext_block;
        logic        ram_exec;
    } fspc_state_s;

    fspc_state_s st_reg;
    fspc_state_s st_next;
    fspc_pins_s  pins_raw;
    fspc_pins_s  pins_s;
    logic        lk_rise;
    logic        lk_fall;
    logic        wr_acc;
    logic        rd_acc;
    logic [7:0]  wd;

    assign pins_raw = '{clk: link_serial_clock, data: link_serial_data_in,
                        sel: prog_select_voltage, tool: tool_socket_strap};

    fspc_link_sampler u_sampler (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .pins_raw  (pins_raw),
        .pins_sync (pins_s),
        .clk_rise  (lk_rise),
        .clk_fall  (lk_fall)
    );

    assign wr_acc = avm_write & ~st_reg.waitreq & avm_byteenable[0];
    assign rd_acc = avm_read & ~st_reg.waitreq;
    assign wd     = avm_writedata[7:0];

    // boot sector at the top nibble, next 4K below it, the rest beyond
    function automatic logic [1:0] sector_of(input logic [15:0] a);
        if (a[15:12] == SEC0_TOP_NIB) begin
            sector_of = 2'h0;
        end else if (a[15:12] == SEC1_TOP_NIB) begin
            sector_of = 2'h1;
        end else begin
            sector_of = 2'h2;
        end
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        fspc_op_s   req;
        logic       legal;
        req   = '0;
        legal = 1'b0;
        st_next       = st_reg;
        st_next.pulse = '0;
        // one-cycle wait state: the answer always comes at the second edge
        st_next.waitreq = ~((avm_read | avm_write) & st_reg.waitreq);
        // the sampled pin decides ownership; software cannot override it
        st_next.owned = pins_s.sel;
        if (pins_s.sel) begin
            st_next.mode = MODE_ICP;
        end else if (pins_s.tool) begin
            st_next.mode = MODE_TOOL;
        end else begin
            st_next.mode = st_reg.swmode;
        end
        st_next.ext_block = st_reg.protect & st_reg.owned;
        st_next.ram_exec  = (st_reg.mode == MODE_ICT) | (st_reg.mode == MODE_ICP);

        if ((avm_read | avm_write) & st_reg.waitreq) begin
            case (avm_address)
                OFS_CTRL_STATUS: st_next.rdata = {24'h000000, st_reg.ctrl};
                OFS_GUARD:       st_next.rdata = {31'h00000000, st_reg.unlocked};
                OFS_OPTION:      st_next.rdata = {31'h00000000, st_reg.protect};
                OFS_MODE:        st_next.rdata = {29'h00000000, st_reg.mode};
                OFS_ADDR:        st_next.rdata = {16'h0000, st_reg.addr};
                OFS_WDATA:       st_next.rdata = {24'h000000, st_reg.wdata};
                OFS_LINK_RX:     st_next.rdata = {23'h000000, st_reg.rx_full, st_reg.rx_byte};
                OFS_LINK_TX:     st_next.rdata = {31'h00000000, st_reg.tx_oe};
                default:         st_next.rdata = 32'h00000000;
            endcase
        end

        if (rd_acc && avm_address == OFS_LINK_RX) begin
            st_next.rx_full = 1'b0;
        end

        if (wr_acc) begin
            case (avm_address)
                OFS_CTRL_STATUS: begin
                    if (st_reg.seq == SEQ_IDLE) begin
                        st_next.ctrl = {2'b00, wd[5:0]};
                        if (|wd[2:0]) begin
                            req.prog   = wd[CS_PROG];
                            req.serase = wd[CS_SERASE] & ~wd[CS_PROG];
                            req.merase = wd[CS_MERASE] & ~wd[CS_SERASE] & ~wd[CS_PROG];
                            req.sector = req.prog ? sector_of(st_reg.addr)
                                                  : wd[CS_SEC_LO +: 2];
                            legal = st_reg.unlocked;
                            if (req.prog | req.serase) begin
                                if (req.sector >= NUM_SECTORS) begin
                                    legal = 1'b0;
                                end
                                if (st_reg.protect) begin
                                    legal = 1'b0;
                                end
                                if (st_reg.mode == MODE_IAP && req.sector == 2'h0) begin
                                    legal = 1'b0;
                                end
                            end
                            if (req.merase && st_reg.mode == MODE_IAP) begin
                                legal = 1'b0;
                            end
                            st_next.unlocked = 1'b0;
                            if (legal) begin
                                st_next.op  = req;
                                st_next.seq = SEQ_ISSUE;
                                st_next.ctrl[CS_BUSY] = 1'b1;
                            end else begin
                                st_next.ctrl[CS_REFUSED] = 1'b1;
                                st_next.ctrl[2:0] = 3'b000;
                            end
                        end
                    end
                end
                OFS_GUARD: begin
                    // any stray value relocks, so a runaway write cannot open the gate
                    st_next.key1_seen = (wd == GUARD_KEY1);
                    st_next.unlocked  = st_reg.key1_seen & (wd == GUARD_KEY2);
                end
                OFS_OPTION: begin
                    if (st_reg.unlocked && st_reg.seq == SEQ_IDLE &&
                        st_reg.mode != MODE_IAP) begin
                        st_next.unlocked = 1'b0;
                        if (wd[0]) begin
                            st_next.protect = 1'b1;
                        end else if (st_reg.protect) begin
                            st_next.unprot_pend = 1'b1;
                            st_next.op  = '{prog: 1'b0, serase: 1'b0, merase: 1'b1,
                                            sector: 2'h0};
                            st_next.seq = SEQ_ISSUE;
                            st_next.ctrl[CS_BUSY] = 1'b1;
                        end
                    end
                end
                OFS_MODE: begin
                    if (wd[2:0] == MODE_USER || wd[2:0] == MODE_IAP ||
                        wd[2:0] == MODE_ICT) begin
                        st_next.swmode = fspc_mode_e'(wd[2:0]);
                    end
                end
                OFS_ADDR: begin
                    if (st_reg.seq == SEQ_IDLE) begin
                        st_next.addr[7:0] = wd;
                        if (avm_byteenable[1]) begin
                            st_next.addr[15:8] = avm_writedata[15:8];
                        end
                    end
                end
                OFS_WDATA: begin
                    if (st_reg.seq == SEQ_IDLE) begin
                        st_next.wdata = wd;
                    end
                end
                OFS_LINK_TX: begin
                    if (st_reg.owned && !st_reg.tx_oe) begin
                        st_next.tx_sh  = wd;
                        st_next.tx_cnt = 4'(LINK_BITS);
                        st_next.tx_oe  = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // program/erase sequencer
        // ------------------------------------------------------------
        case (st_reg.seq)
            SEQ_IDLE: begin
            end
            SEQ_ISSUE: begin
                st_next.pulse = st_reg.op;
                st_next.seq   = SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (flash_done) begin
                    st_next.seq = SEQ_IDLE;
                    st_next.ctrl[CS_BUSY] = 1'b0;
                    st_next.ctrl[2:0] = 3'b000;
                    if (st_reg.unprot_pend) begin
                        st_next.protect     = 1'b0;
                        st_next.unprot_pend = 1'b0;
                    end
                end
            end
            default: begin
                st_next.seq = SEQ_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // serial link: tool samples on rising edge, device drives on falling
        // ------------------------------------------------------------
        if (!pins_s.sel) begin
            st_next.tx_oe  = 1'b0;
            st_next.rx_cnt = 3'h0;
        end else if (st_reg.tx_oe) begin
            if (lk_fall && st_reg.tx_cnt != 4'(LINK_BITS)) begin
                st_next.tx_sh = {st_reg.tx_sh[6:0], 1'b0};
            end
            if (lk_rise) begin
                st_next.tx_cnt = st_reg.tx_cnt - 4'h1;
                if (st_reg.tx_cnt == 4'h1) begin
                    st_next.tx_oe = 1'b0;
                end
            end
        end else if (lk_rise) begin
            st_next.rx_sh  = {st_reg.rx_sh[6:0], pins_s.data};
            st_next.rx_cnt = st_reg.rx_cnt + 3'h1;
            if (st_reg.rx_cnt == 3'h7) begin
                st_next.rx_byte = {st_reg.rx_sh[6:0], pins_s.data};
                st_next.rx_full = 1'b1; // set wins over a clearing read
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg         <= '0;
            st_reg.waitreq <= 1'b1;
            st_reg.ctrl    <= CTRL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign avm_readdata         = st_reg.rdata;
    assign avm_waitrequest      = st_reg.waitreq;
    assign link_serial_data_out = st_reg.tx_sh[7];
    assign link_serial_data_oe  = st_reg.tx_oe;
    assign flash_addr           = st_reg.addr;
    assign flash_wdata          = st_reg.wdata;
    assign flash_prog           = st_reg.pulse.prog;
    assign flash_sector_erase   = st_reg.pulse.serase;
    assign flash_mass_erase     = st_reg.pulse.merase;
    assign flash_sector         = st_reg.op.sector;
    assign link_pins_owned      = st_reg.owned;
    assign ext_read_block       = st_reg.ext_block;
    assign ram_exec_mode        = st_reg.ram_exec;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_unprot_start;
        $rose(st_reg.unprot_pend);
    endsequence
    sequence s_mass_pulse;
        ##1 flash_mass_erase;
    endsequence

    property p_answer_one;
        @(posedge ref_clk) disable iff (!reset_n)
        ((avm_read | avm_write) && avm_waitrequest) |=> !avm_waitrequest;
    endproperty
    a_answer_one: assert property (p_answer_one) else $error("no answer after one wait");

    property p_boot_locked;
        @(posedge ref_clk) disable iff (!reset_n)
        (flash_prog | flash_sector_erase) && st_reg.mode == MODE_IAP |-> flash_sector != 2'h0;
    endproperty
    a_boot_locked: assert property (p_boot_locked) else $error("boot sector touched");

    property p_no_iap_mass;
        @(posedge ref_clk) disable iff (!reset_n)
        flash_mass_erase |-> st_reg.mode != MODE_IAP;
    endproperty
    a_no_iap_mass: assert property (p_no_iap_mass) else $error("mass erase in app mode");

    property p_one_op;
        @(posedge ref_clk) disable iff (!reset_n)
        $onehot0({flash_prog, flash_sector_erase, flash_mass_erase});
    endproperty
    a_one_op: assert property (p_one_op) else $error("two flash ops at once");

    property p_sector_exists;
        @(posedge ref_clk) disable iff (!reset_n)
        flash_sector_erase |-> flash_sector < NUM_SECTORS;
    endproperty
    a_sector_exists: assert property (p_sector_exists) else $error("absent sector");

    property p_protect_write;
        @(posedge ref_clk) disable iff (!reset_n)
        flash_prog |-> !st_reg.protect;
    endproperty
    a_protect_write: assert property (p_protect_write) else $error("write while protected");

    property p_unprot_erase;
        @(posedge ref_clk) disable iff (!reset_n)
        s_unprot_start |-> s_mass_pulse;
    endproperty
    a_unprot_erase: assert property (p_unprot_erase) else $error("no auto erase");

    property p_unprot_after;
        @(posedge ref_clk) disable iff (!reset_n)
        $fell(st_reg.protect) |-> $past(st_reg.unprot_pend) && $past(flash_done);
    endproperty
    a_unprot_after: assert property (p_unprot_after) else $error("protect left early");

    property p_guarded;
        @(posedge ref_clk) disable iff (!reset_n)
        $rose(st_reg.seq == SEQ_ISSUE) |-> $past(st_reg.unlocked);
    endproperty
    a_guarded: assert property (p_guarded) else $error("op without unlock");

    property p_pins_owned;
        @(posedge ref_clk) disable iff (!reset_n)
        link_serial_data_oe |-> link_pins_owned;
    endproperty
    a_pins_owned: assert property (p_pins_owned) else $error("drive without link");

endmodule
`default_nettype wire

// *** rtl/fspc_pkg.sv ***
// constants, types and register map of the flash sector program control
package fspc_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [5:0] OFS_CTRL_STATUS = 6'h00;
    localparam logic [5:0] OFS_GUARD       = 6'h04;
    localparam logic [5:0] OFS_OPTION      = 6'h08;
    localparam logic [5:0] OFS_MODE        = 6'h0c;
    localparam logic [5:0] OFS_ADDR        = 6'h10;
    localparam logic [5:0] OFS_WDATA       = 6'h14;
    localparam logic [5:0] OFS_LINK_RX     = 6'h18;
    localparam logic [5:0] OFS_LINK_TX     = 6'h1c;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int         CS_PROG       = 0;
    localparam int         CS_SERASE     = 1;
    localparam int         CS_MERASE     = 2;
    localparam int         CS_SEC_LO     = 3;
    localparam int         CS_REFUSED    = 6;
    localparam int         CS_BUSY       = 7;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] GUARD_KEY1    = 8'h56;
    localparam logic [7:0] GUARD_KEY2    = 8'hae;
    localparam int         LINK_BITS     = 8;

    // ----------------------------------------------------------------
    // array layout
    // ----------------------------------------------------------------
    localparam int         FLASH_KBYTES  = 16;
    localparam logic [1:0] NUM_SECTORS   = (FLASH_KBYTES <= 4) ? 2'h1 :
                                           (FLASH_KBYTES <= 8) ? 2'h2 : 2'h3;
    localparam logic [3:0] SEC0_TOP_NIB  = 4'hf;
    localparam logic [3:0] SEC1_TOP_NIB  = 4'he;

    // ----------------------------------------------------------------
    // enumerations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_USER = 3'b000,
        MODE_TOOL = 3'b001,
        MODE_ICP  = 3'b010,
        MODE_IAP  = 3'b011,
        MODE_ICT  = 3'b100
    } fspc_mode_e;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_ISSUE = 2'b01,
        SEQ_WAIT  = 2'b10
    } fspc_seq_e;

    typedef struct packed {
        logic        prog;
        logic        serase;
        logic        merase;
        logic [1:0]  sector;
    } fspc_op_s;

    typedef struct packed {
        logic        clk;
        logic        data;
        logic        sel;
        logic        tool;
    } fspc_pins_s;

endpackage

// *** rtl/fspc_link_sampler.sv ***
// two-stage synchroniser and edge finder for the link and strap pins
`timescale 1ns/1ps
`default_nettype none
module fspc_link_sampler
    import fspc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire fspc_pins_s pins_raw,
    output fspc_pins_s      pins_sync,
    output logic            clk_rise,
    output logic            clk_fall
);

    typedef struct packed {
        logic [3:0] meta;
        logic [3:0] sync;
        logic       clk_prev;
    } fspc_smp_s;

    fspc_smp_s st_reg;
    fspc_smp_s st_next;
    logic [3:0] raw_bits;

    assign raw_bits = pins_raw;

    // ----------------------------------------------------------------
    // per-pin two flip-flops; only the second stage is read
    // ----------------------------------------------------------------
    always_comb begin
        st_next          = st_reg;
        st_next.meta     = raw_bits;
        st_next.sync     = st_reg.meta;
        st_next.clk_prev = st_reg.sync[3];
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins_sync = st_reg.sync;
    assign clk_rise  = st_reg.sync[3] & ~st_reg.clk_prev;
    assign clk_fall  = ~st_reg.sync[3] & st_reg.clk_prev;

endmodule
`default_nettype wire

// *** sim/fspc_tool_model.sv ***
// programming tool stand-in on the in-circuit link
`timescale 1ns/1ps
`default_nettype none
module fspc_tool_model (
    input  wire logic dev_out,
    input  wire logic dev_oe,
    output logic      link_clk,
    output wire logic link_data,
    output logic      sel,
    output logic      strap
);
    logic drv;
    initial begin
        link_clk = 0;
        drv = 0;
        sel = 0;
        strap = 0;
    end
    // released data shows the inverse of its last bit, not a stale copy
    assign link_data = dev_oe ? dev_out : drv;
    task automatic attach(input logic v, s);
        #2 sel = v;
        strap = s;
    endtask
    // device drives after our falling edge; we sample at our rising edge
    task automatic recv(output logic [7:0] b);
        #3 link_clk = 0;
        for (int i = 7; i >= 0; i--) begin
            #40 link_clk = 1;
            b[i] = link_data;
            #40 link_clk = 0;
        end
    endtask
    // clock stands low between frames; msb first, 80 ns bit time
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #3 drv = b[i];
            #37 link_clk = 1;
            #40 link_clk = 0;
        end
        #5 drv = ~b[0];
    endtask
endmodule
`default_nettype wire

// *** sim/flash_sector_program_control_test.sv ***
// self-checking bench of the flash sector program control
`timescale 1ns/1ps
`default_nettype none
module flash_sector_program_control_test;
    import fspc_pkg::*;
    logic ref_clk = 0, reset_n = 0, rd = 0, wr = 0, done = 0;
    logic [5:0] adr = 0;
    logic [31:0] wd = 0, rdat, lfsr = 32'ha7c8c05f;
    logic [2:0] seen = 0, dly = 0;
    int error_cnt = 0, cmp_count = 0;
    wire logic lclk, ldat, sel, strap, dout, doe, owned, xblk, ram, wreq, fp, fs, fm;
    wire logic [31:0] q;
    wire logic [15:0] fa;
    wire logic [7:0] fwd;
    wire logic [1:0] fsec;
    fspc_top uut (.ref_clk, .reset_n, .avm_address(adr), .avm_read(rd), .avm_write(wr),
        .avm_byteenable(4'hf), .avm_writedata(wd), .avm_readdata(q), .avm_waitrequest(wreq),
        .link_serial_clock(lclk), .link_serial_data_in(ldat), .link_serial_data_out(dout),
        .link_serial_data_oe(doe), .prog_select_voltage(sel), .tool_socket_strap(strap),
        .flash_done(done), .flash_addr(fa), .flash_wdata(fwd), .flash_prog(fp),
        .flash_sector_erase(fs), .flash_mass_erase(fm), .flash_sector(fsec),
        .link_pins_owned(owned), .ext_read_block(xblk), .ram_exec_mode(ram));
    fspc_tool_model tool (.dev_out(dout), .dev_oe(doe), .link_clk(lclk), .link_data(ldat),
        .sel(sel), .strap(strap));
    initial forever #5 ref_clk = ~ref_clk;
    // --------
    // flash array stand-in: answers each pulse five cycles later
    // --------
    always @(posedge ref_clk) begin
        done <= (dly == 3'h1);
        dly <= (fp | fs | fm) ? 3'h4 : (dly != 3'h0 ? dly - 3'h1 : 3'h0);
        if (fp | fs | fm) seen <= {fm, fs, fp};
    end
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [2:0] ek(input logic in_application_programming, p, input logic [7:0] c,
                                      input logic [15:0] a);
        logic [1:0] s;
        s = !c[0] ? c[4:3] : a[15:12] == SEC0_TOP_NIB ? 2'h0 :
            a[15:12] == SEC1_TOP_NIB ? 2'h1 : 2'h2;
        if (c[0] | c[1])
            return (p || (in_application_programming && s == 2'h0) || s >= NUM_SECTORS) ? 3'h0 : {1'b0, c[1] & !c[0], c[0]};
        return {c[2] & !in_application_programming, 2'h0};
    endfunction
    task chk(input string n, input logic [31:0] e, s);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task print_verdict;
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int i;
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (wreq === 1'b0) break;
        end
        if (i == 50) begin
            error_cnt++;
            print_verdict();
        end
        rdat = q;
        wr <= 0;
        rd <= 0;
        @(posedge ref_clk);
    endtask
    task unl;
        bus(1, OFS_GUARD, {24'h0, GUARD_KEY1});
        bus(1, OFS_GUARD, {24'h0, GUARD_KEY2});
    endtask
    task op(input logic u, in_application_programming, p, input logic [7:0] c, input logic [15:0] a);
        logic [7:0] d;
        d = 8'(rnd());
        bus(1, OFS_ADDR, {16'h0, a});
        bus(1, OFS_WDATA, {24'h0, d});
        if (u) unl();
        seen = 0;
        bus(1, OFS_CTRL_STATUS, {24'h0, c});
        for (int i = 0; i < 20; i++) begin
            bus(0, OFS_CTRL_STATUS, 0);
            if (rdat[CS_BUSY] === 1'b0) break;
        end
        if (rdat[CS_BUSY] !== 1'b0) begin
            error_cnt++;
            print_verdict();
        end
        chk("op kind", u ? ek(in_application_programming, p, c, a) : 3'h0, seen);
        if (u) chk("refused", ek(in_application_programming, p, c, a) == 3'h0, rdat[CS_REFUSED]);
        if (seen === 3'b001) chk("flash byte", {a, d}, {fa, fwd});
        if (seen === 3'b010) chk("sector", c[4:3], fsec);
    endtask
    initial begin
        logic [7:0] b, r;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1;
        @(posedge ref_clk);
        bus(0, OFS_CTRL_STATUS, 0);
        chk("ctrl reset", {24'h0, CTRL_RESET}, rdat);
        bus(0, 6'h20, 0);
        chk("unmapped", 0, rdat);
        op(0, 0, 0, 8'h01, 16'he000);
        op(1, 0, 0, 8'h01, {4'he, 12'(rnd())});
        op(1, 0, 0, 8'h12, 0);
        op(1, 0, 0, 8'h1a, 0);
        op(1, 0, 0, 8'h04, 0);
        bus(1, OFS_MODE, 3);
        op(1, 1, 0, 8'h01, {4'hf, 12'(rnd())});
        op(1, 1, 0, 8'h02, 0);
        op(1, 1, 0, 8'h0a, 0);
        op(1, 1, 0, 8'h04, 0);
        bus(1, OFS_MODE, 0);
        unl();
        bus(1, OFS_OPTION, 1);
        op(1, 0, 1, 8'h01, 16'he000);
        chk("read block", 0, xblk);
        unl();
        seen = 0;
        bus(1, OFS_OPTION, 0);
        repeat (10) @(posedge ref_clk);
        chk("auto erase", 3'b100, seen);
        bus(0, OFS_OPTION, 0);
        chk("protect bit", 0, rdat);
        bus(1, OFS_MODE, 4);
        repeat (3) @(posedge ref_clk);
        chk("ram exec", 1, ram);
        bus(1, OFS_MODE, 0);
        tool.attach(0, 1);
        repeat (6) @(posedge ref_clk);
        bus(0, OFS_MODE, 0);
        chk("mode", {29'h0, MODE_TOOL}, rdat);
        chk("ram exec", 0, ram);
        op(1, 0, 0, 8'h02, 0);
        tool.attach(1, 0);
        repeat (6) @(posedge ref_clk);
        chk("pins owned", 1, owned);
        chk("ram exec", 1, ram);
        bus(0, OFS_MODE, 0);
        chk("mode", {29'h0, MODE_ICP}, rdat);
        op(1, 0, 0, 8'h01, {4'hf, 12'(rnd())});
        unl();
        bus(1, OFS_OPTION, 1);
        repeat (4) @(posedge ref_clk);
        chk("read block", 1, xblk);
        b = 8'(rnd());
        tool.send(b);
        repeat (6) @(posedge ref_clk);
        bus(0, OFS_LINK_RX, 0);
        chk("rx byte", {23'h0, 1'b1, b}, rdat);
        b = 8'(rnd());
        bus(1, OFS_LINK_TX, {24'h0, b});
        chk("tx drive", 1, doe);
        tool.recv(r);
        chk("tx byte", b, r);
        repeat (4) @(posedge ref_clk);
        chk("tx idle", 0, doe);
        print_verdict();
    end
endmodule
`default_nettype wire
